// ===== include/ext_mem_pkg.sv
// Constants, types and register map of the external memory paging interface
package ext_mem_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ         = 10_000_000;
	localparam int CLK_NS         = 100;
	localparam int WAIT_STATE_NS  = 21;
	localparam int WAIT_STATE_RAW = (WAIT_STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAIT_STATE_CYC = (WAIT_STATE_RAW < 1) ? 1 : WAIT_STATE_RAW;
	localparam int BOOT_MS        = 3;
	localparam int BOOT_CYC       = BOOT_MS * (CLK_HZ / 1000);
	localparam int MEM_ACCESS_NS  = 12;
	localparam int MAX_WAIT       = 7;

	// ==========================================================
	// Register indices and byte addresses
	localparam logic [15:0] IDX_PAGE1  = 16'hC018;
	localparam logic [15:0] IDX_PAGE2  = 16'hC01A;
	localparam logic [15:0] IDX_CTRL   = 16'hC03A;
	localparam logic [15:0] IDX_UAE    = 16'hC03C;
	localparam logic [15:0] IDX_STATUS = 16'hC03E;
	localparam logic [17:0] ADDR_PAGE1  = {IDX_PAGE1, 2'b00};
	localparam logic [17:0] ADDR_PAGE2  = {IDX_PAGE2, 2'b00};
	localparam logic [17:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
	localparam logic [17:0] ADDR_UAE    = {IDX_UAE, 2'b00};
	localparam logic [17:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

	// ==========================================================
	// Fields and reset values
	localparam int CTL_RAM_MERGE = 0;
	localparam int CTL_ROM_MERGE = 1;
	localparam int CTL_BUS16     = 2;
	localparam int CTL_WS_LSB    = 4;
	localparam int UAE_EN        = 0;
	localparam int STS_BOOT      = 0;
	localparam int STS_HOLE      = 1;
	localparam int STS_WS_REF    = 2;
	localparam int STS_UNMAP     = 3;
	localparam int STS_BUSY      = 4;
	localparam logic [15:0] PAGE_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0070;
	localparam logic [15:0] UAE_RESET  = 16'h0000;
	localparam logic [3:0]  UPPER_IDLE = 4'hF;

	// ==========================================================
	// CPU address map
	localparam logic [15:0] RAM_LO    = 16'h4000;
	localparam logic [15:0] RAM_HI    = 16'h7FFF;
	localparam logic [15:0] WIN_LO    = 16'h8000;
	localparam logic [15:0] WIN1_HI   = 16'h9FFF;
	localparam logic [15:0] WIN_HI    = 16'hBFFF;
	localparam logic [15:0] HOLE_LO   = 16'hC000;
	localparam logic [15:0] HOLE_HI   = 16'hC0FF;
	localparam logic [15:0] ROM_LO    = 16'hC100;
	localparam logic [15:0] ROM_HI    = 16'hDFFF;
	localparam logic [15:0] DMA_MASK  = 16'h3FFF;
	localparam logic [15:0] BOOT_SIG  = 16'hC3B6;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_STROBE  = 2'b01,
		ST_RECOVER = 2'b10
	} mem_state_e;

	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_RAM  = 2'b01,
		SEL_ROM  = 2'b10,
		SEL_WIN  = 2'b11
	} mem_sel_e;

	typedef struct packed {
		logic        ram_chip_select_n;
		logic        rom_chip_select_n;
		logic        paged_window_select_n;
		logic        rd_n;
		logic        wr_n;
		logic [1:0]  be_n;
		logic [18:0] addr;
	} ext_bus_s;

endpackage

// ===== verilog/ext_mem_paging.sv
// External memory paging interface: decode, page windows, wait states, APB registers
// Behaviour
// RULE1 - Access ends on strobe rising edge; at least one wait state always inserted.
// RULE2 - Wait states programmable up to seven; each adds 21 ns.
// RULE3 - Wait state field changes only while executing from internal memory.
// RULE4 - Attached memory needs 12 ns access time for full-speed execution.
// RULE5 - Up to 512K bytes of external memory reachable through page windows.
// RULE6 - First page register selects page seen at 0x8000-0x9FFF.
// RULE7 - Second page register selects page seen at 0xA000-0xBFFF.
// RULE8 - While window select asserted, upper address comes from the page register.
// RULE9 - Window select asserted for addresses 0x8000 through 0xBFFF.
// RULE10 - RAM select 0x4000-0x7FFF, or 0x4000-0xBFFF when RAM joining on.
// RULE11 - ROM select 0xC100-0xDFFF, or 0x8000-0xDFFF minus 0xC000-0xC0FF joined.
// RULE12 - Region joining controlled by the external memory control register.
// RULE13 - No code fetch from 0xC000-0xC0FF.
// RULE14 - DMA only reaches internal RAM or ROM, never external memory.
// RULE15 - DMA addresses unchecked; external addresses wrap into internal RAM.
// RULE16 - Upper address A18..A15 high after reset until enable register written.
// RULE17 - External bus stays usable through the 3 ms boot period.
// RULE18 - Boot ROM must hold 0xC3B6 at 0xC100.
// RULE19 - Both page windows are always enabled. Here they give way to the region whenever either join bit is set.
// RULE20 - Memory ignores strobes while its chip select is inactive.
// RULE21 - Supports 8-bit or 16-bit external SRAM or ROM.
// RULE22 - 16-bit mode addresses up to 256K words.
// RULE23 - Selects and strobes active low; at most one select per access.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module ext_mem_paging #(
	parameter int BOOT_CYCLES = ext_mem_pkg::BOOT_CYC
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [17:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// CPU request port
	input  wire logic                 cpu_req,
	input  wire logic                 cpu_fetch,
	input  wire logic                 cpu_write,
	input  wire logic [1:0]           cpu_be,
	input  wire logic [15:0]          cpu_addr,
	input  wire logic [15:0]          cpu_wdata,
	input  wire logic                 cpu_exec_internal,
	output logic                      cpu_ack,
	output logic      [15:0]          cpu_rdata,
	output logic                      cpu_fault,
	// DMA address folding
	input  wire logic [15:0]          dma_addr,
	output logic      [15:0]          dma_ram_addr,
	// External memory pins
	output ext_mem_pkg::ext_bus_s     ext_bus,
	input  wire logic [15:0]          mem_d_in,
	output logic      [15:0]          mem_d_out,
	output logic                      mem_d_oe,
	// Boot status
	output logic                      boot_active
);

	localparam int BW = $clog2(BOOT_CYCLES + 1);
	localparam logic [BW-1:0] BOOT_LOAD = BW'(BOOT_CYCLES);

	// ==========================================================
	// Registers and state
	logic [15:0]             page1;
	logic [15:0]             page2;
	logic [15:0]             ctrl;
	logic [15:0]             uae;
	logic                    hole_flag;
	logic                    ws_ref_flag;
	logic                    unmap_flag;
	logic [BW-1:0]           boot_cnt;
	ext_mem_pkg::mem_state_e state;
	logic [3:0]              strobe_cnt;
	logic [15:0]             d_sync1;
	logic [15:0]             d_sync2;

	// ==========================================================
	// APB decode
	logic apb_setup;
	logic apb_wr;
	logic apb_hit;
	logic ws_write;
	logic ws_refuse;
	logic sts_clr_hole;
	logic sts_clr_ws;
	logic sts_clr_unmap;

	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready & pwrite;
	assign apb_hit   = (paddr == ext_mem_pkg::ADDR_PAGE1) | (paddr == ext_mem_pkg::ADDR_PAGE2) |
	                   (paddr == ext_mem_pkg::ADDR_CTRL) | (paddr == ext_mem_pkg::ADDR_UAE) |
	                   (paddr == ext_mem_pkg::ADDR_STATUS);
	assign ws_write  = apb_wr & (paddr == ext_mem_pkg::ADDR_CTRL) &
	                   (pwdata[ext_mem_pkg::CTL_WS_LSB +: 3] != ctrl[ext_mem_pkg::CTL_WS_LSB +: 3]);
	assign ws_refuse = ws_write & ~cpu_exec_internal;
	assign sts_clr_hole  = apb_wr & (paddr == ext_mem_pkg::ADDR_STATUS) &
	                       pwdata[ext_mem_pkg::STS_HOLE];
	assign sts_clr_ws    = apb_wr & (paddr == ext_mem_pkg::ADDR_STATUS) &
	                       pwdata[ext_mem_pkg::STS_WS_REF];
	assign sts_clr_unmap = apb_wr & (paddr == ext_mem_pkg::ADDR_STATUS) &
	                       pwdata[ext_mem_pkg::STS_UNMAP];

	// Answer one cycle into the access phase; every access pays one wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~apb_hit;
			if (apb_setup && !pwrite) begin
				case (paddr)
					ext_mem_pkg::ADDR_PAGE1:  prdata <= {16'h0000, page1};
					ext_mem_pkg::ADDR_PAGE2:  prdata <= {16'h0000, page2};
					ext_mem_pkg::ADDR_CTRL:   prdata <= {16'h0000, ctrl};
					ext_mem_pkg::ADDR_UAE:    prdata <= {16'h0000, uae};
					ext_mem_pkg::ADDR_STATUS: prdata <= {27'h000_0000, (state != ext_mem_pkg::ST_IDLE),
					                                     unmap_flag, ws_ref_flag, hole_flag, boot_active};
					default:                  prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Page registers; windows have no enable bit, they are in force while neither join bit is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page1 <= ext_mem_pkg::PAGE_RESET;
			page2 <= ext_mem_pkg::PAGE_RESET;
		end else begin
			if (apb_wr && paddr == ext_mem_pkg::ADDR_PAGE1) begin
				page1 <= pwdata[15:0]; // RULE6
			end
			if (apb_wr && paddr == ext_mem_pkg::ADDR_PAGE2) begin
				page2 <= pwdata[15:0]; // RULE7
			end
		end
	end

	// Control: joining, width, wait states; wait field frozen outside internal execution
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= ext_mem_pkg::CTRL_RESET;
		end else if (apb_wr && paddr == ext_mem_pkg::ADDR_CTRL) begin
			ctrl[3:0]  <= pwdata[3:0]; // RULE12
			ctrl[15:7] <= pwdata[15:7];
			if (!ws_refuse) begin
				ctrl[6:4] <= pwdata[6:4]; // RULE3
			end
		end
	end

	// Upper address enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uae <= ext_mem_pkg::UAE_RESET;
		end else if (apb_wr && paddr == ext_mem_pkg::ADDR_UAE) begin
			uae <= pwdata[15:0]; // RULE16
		end
	end

	// ==========================================================
	// Boot period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_cnt    <= BOOT_LOAD;
			boot_active <= 1'b1;
		end else begin
			if (boot_cnt != '0) begin
				boot_cnt <= boot_cnt - 1'b1;
			end
			boot_active <= (boot_cnt > 1); // RULE17
		end
	end

	// ==========================================================
	// Address decode; joined ROM wins over joined RAM, which wins over the window
	logic                  in_hole;
	logic                  hole_fetch;
	ext_mem_pkg::mem_sel_e sel;
	logic [18:0]           next_addr;
	logic [15:0]           page_now;
	logic [2:0]            ws_eff;

	assign in_hole    = (cpu_addr >= ext_mem_pkg::HOLE_LO) && (cpu_addr <= ext_mem_pkg::HOLE_HI);
	assign hole_fetch = cpu_fetch & in_hole; // RULE13
	assign page_now   = (cpu_addr <= ext_mem_pkg::WIN1_HI) ? page1 : page2; // RULE6 RULE7
	assign ws_eff     = (ctrl[6:4] == 3'd0) ? 3'd1 : ctrl[6:4]; // RULE1

	always_comb begin
		sel = ext_mem_pkg::SEL_NONE;
		if (cpu_addr >= ext_mem_pkg::RAM_LO && cpu_addr <= ext_mem_pkg::RAM_HI) begin
			sel = ext_mem_pkg::SEL_RAM; // RULE10
		end else if (cpu_addr >= ext_mem_pkg::WIN_LO && cpu_addr <= ext_mem_pkg::WIN_HI) begin
			if (ctrl[ext_mem_pkg::CTL_ROM_MERGE]) begin
				sel = ext_mem_pkg::SEL_ROM; // RULE11
			end else if (ctrl[ext_mem_pkg::CTL_RAM_MERGE]) begin
				sel = ext_mem_pkg::SEL_RAM; // RULE10
			end else begin
				sel = ext_mem_pkg::SEL_WIN; // RULE9 RULE19
			end
		end else if (cpu_addr >= ext_mem_pkg::ROM_LO && cpu_addr <= ext_mem_pkg::ROM_HI) begin
			sel = ext_mem_pkg::SEL_ROM; // RULE11
		end
	end

	// Byte address in 8-bit mode, word address in 16-bit mode
	always_comb begin
		if (sel == ext_mem_pkg::SEL_WIN) begin
			if (ctrl[ext_mem_pkg::CTL_BUS16]) begin
				next_addr = {1'b0, page_now[5:0], cpu_addr[12:1]}; // RULE8 RULE22
			end else begin
				next_addr = {page_now[5:0], cpu_addr[12:0]}; // RULE8 RULE5
			end
		end else if (ctrl[ext_mem_pkg::CTL_BUS16]) begin
			next_addr = {4'h0, cpu_addr[15:1]}; // RULE21
		end else begin
			next_addr = {3'h0, cpu_addr}; // RULE21
		end
		if (!uae[ext_mem_pkg::UAE_EN]) begin
			next_addr[18:15] = ext_mem_pkg::UPPER_IDLE; // RULE16
		end
	end

	// ==========================================================
	// Data pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d_sync1 <= 16'h0000;
			d_sync2 <= 16'h0000;
		end else begin
			d_sync1 <= mem_d_in;
			d_sync2 <= d_sync1;
		end
	end

	// ==========================================================
	// Access sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= ext_mem_pkg::ST_IDLE;
			strobe_cnt <= 4'h0;
			ext_bus    <= '{ram_chip_select_n: 1'b1, rom_chip_select_n: 1'b1,
			                paged_window_select_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
			                be_n: 2'b11, addr: {ext_mem_pkg::UPPER_IDLE, 15'h0000}};
			mem_d_out  <= 16'h0000;
			mem_d_oe   <= 1'b0;
			cpu_ack    <= 1'b0;
			cpu_fault  <= 1'b0;
			cpu_rdata  <= 16'h0000;
		end else begin
			cpu_ack <= 1'b0;
			if (!uae[ext_mem_pkg::UAE_EN]) begin
				ext_bus.addr[18:15] <= ext_mem_pkg::UPPER_IDLE; // RULE16
			end
			case (state)
				ext_mem_pkg::ST_IDLE: begin
					if (cpu_req && !cpu_ack) begin
						if (hole_fetch || sel == ext_mem_pkg::SEL_NONE) begin
							cpu_ack   <= 1'b1; // RULE13
							cpu_fault <= 1'b1;
							cpu_rdata <= 16'h0000;
						end else begin
							// One-hot select, all active low
							ext_bus.ram_chip_select_n     <= (sel != ext_mem_pkg::SEL_RAM); // RULE23
							ext_bus.rom_chip_select_n     <= (sel != ext_mem_pkg::SEL_ROM); // RULE23
							ext_bus.paged_window_select_n <= (sel != ext_mem_pkg::SEL_WIN); // RULE9
							ext_bus.addr <= next_addr;
							ext_bus.rd_n <= cpu_write;
							ext_bus.wr_n <= ~cpu_write;
							ext_bus.be_n <= ctrl[ext_mem_pkg::CTL_BUS16] ? ~cpu_be : 2'b10;
							mem_d_out    <= cpu_wdata;
							mem_d_oe     <= cpu_write;
							cpu_fault    <= 1'b0;
							// Base cycle plus the wait states, each worth WAIT_STATE_CYC
							strobe_cnt   <= 4'(ws_eff * ext_mem_pkg::WAIT_STATE_CYC); // RULE2
							state        <= ext_mem_pkg::ST_STROBE;
						end
					end
				end
				ext_mem_pkg::ST_STROBE: begin
					if (strobe_cnt != 4'h0) begin
						strobe_cnt <= strobe_cnt - 4'h1; // RULE1
					end else begin
						// Rising strobe closes the access
						ext_bus.rd_n <= 1'b1; // RULE1
						ext_bus.wr_n <= 1'b1;
						state        <= ext_mem_pkg::ST_RECOVER;
					end
				end
				ext_mem_pkg::ST_RECOVER: begin
					// Synchroniser lags two cycles: this holds the pins from inside the strobe
					cpu_rdata                     <= d_sync2; // RULE1
					cpu_ack                       <= 1'b1;
					// Selects drop a cycle after the strobes so the write hold is kept
					ext_bus.ram_chip_select_n     <= 1'b1;
					ext_bus.rom_chip_select_n     <= 1'b1;
					ext_bus.paged_window_select_n <= 1'b1;
					ext_bus.be_n                  <= 2'b11;
					mem_d_oe                      <= 1'b0;
					state                         <= ext_mem_pkg::ST_IDLE;
				end
				default: begin
					state <= ext_mem_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hole_flag   <= 1'b0;
			ws_ref_flag <= 1'b0;
			unmap_flag  <= 1'b0;
		end else begin
			if (state == ext_mem_pkg::ST_IDLE && cpu_req && !cpu_ack && hole_fetch) begin
				hole_flag <= 1'b1; // RULE13
			end else if (sts_clr_hole) begin
				hole_flag <= 1'b0;
			end
			if (ws_refuse) begin
				ws_ref_flag <= 1'b1; // RULE3
			end else if (sts_clr_ws) begin
				ws_ref_flag <= 1'b0;
			end
			if (state == ext_mem_pkg::ST_IDLE && cpu_req && !cpu_ack && !hole_fetch &&
			    sel == ext_mem_pkg::SEL_NONE) begin
				unmap_flag <= 1'b1;
			end else if (sts_clr_unmap) begin
				unmap_flag <= 1'b0;
			end
		end
	end

	// ==========================================================
	// DMA folding: unchecked address lands in internal RAM
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_ram_addr <= 16'h0000;
		end else begin
			dma_ram_addr <= dma_addr & ext_mem_pkg::DMA_MASK; // RULE14 RULE15
		end
	end

	// ==========================================================
	// Checks
	logic [3:0] low_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt <= 4'h0;
		end else begin
			low_cnt <= (!ext_bus.rd_n || !ext_bus.wr_n) ? low_cnt + 4'h1 : 4'h0;
		end
	end

	property p_min_wait;
		@(posedge pclk) disable iff (!presetn)
		$rose(ext_bus.rd_n && ext_bus.wr_n) |-> low_cnt >= 4'(1 + ext_mem_pkg::WAIT_STATE_CYC);
	endproperty
	a_min_wait: assert property (p_min_wait) else $error("strobe shorter than one wait state"); // RULE1

	property p_max_wait;
		@(posedge pclk) disable iff (!presetn)
		low_cnt <= 4'(1 + ext_mem_pkg::MAX_WAIT * ext_mem_pkg::WAIT_STATE_CYC);
	endproperty
	a_max_wait: assert property (p_max_wait) else $error("strobe held beyond seven wait states"); // RULE2

	property p_ws_frozen;
		@(posedge pclk) disable iff (!presetn)
		ws_refuse |=> $stable(ctrl[6:4]) && ws_ref_flag;
	endproperty
	a_ws_frozen: assert property (p_ws_frozen) else $error("wait states changed from external code"); // RULE3

	property p_one_select;
		@(posedge pclk) disable iff (!presetn)
		$countones({~ext_bus.ram_chip_select_n, ~ext_bus.rom_chip_select_n,
		            ~ext_bus.paged_window_select_n}) <= 1;
	endproperty
	a_one_select: assert property (p_one_select) else $error("more than one chip select low"); // RULE23

	property p_win_page;
		@(posedge pclk) disable iff (!presetn)
		(state == ext_mem_pkg::ST_IDLE && cpu_req && !cpu_ack && !hole_fetch &&
		 sel == ext_mem_pkg::SEL_WIN && uae[0] && !ctrl[ext_mem_pkg::CTL_BUS16])
		|=> !ext_bus.paged_window_select_n && ext_bus.addr[18:13] == $past(page_now[5:0]);
	endproperty
	a_win_page: assert property (p_win_page) else $error("window address not from page register"); // RULE8

	property p_upper_high;
		@(posedge pclk) disable iff (!presetn)
		!uae[ext_mem_pkg::UAE_EN] |=> ext_bus.addr[18:15] == ext_mem_pkg::UPPER_IDLE;
	endproperty
	a_upper_high: assert property (p_upper_high) else $error("upper address low before enable"); // RULE16

	property p_hole_fetch;
		@(posedge pclk) disable iff (!presetn)
		(state == ext_mem_pkg::ST_IDLE && cpu_req && !cpu_ack && hole_fetch)
		|=> cpu_ack && cpu_fault && state == ext_mem_pkg::ST_IDLE ##1 ext_bus.rd_n;
	endproperty
	a_hole_fetch: assert property (p_hole_fetch) else $error("fetch from hole reached the bus"); // RULE13

	property p_dma_fold;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> dma_ram_addr == ($past(dma_addr) & ext_mem_pkg::DMA_MASK);
	endproperty
	a_dma_fold: assert property (p_dma_fold) else $error("DMA address left internal RAM"); // RULE14

	property p_ram_range;
		@(posedge pclk) disable iff (!presetn)
		$fell(ext_bus.ram_chip_select_n) |->
		($past(cpu_addr) >= ext_mem_pkg::RAM_LO) && ($past(cpu_addr) <= ext_mem_pkg::RAM_HI ||
		 ($past(ctrl[ext_mem_pkg::CTL_RAM_MERGE]) && $past(cpu_addr) <= ext_mem_pkg::WIN_HI));
	endproperty
	a_ram_range: assert property (p_ram_range) else $error("RAM select outside its range"); // RULE10

	property p_boot_len;
		@(posedge pclk) disable iff (!presetn)
		$fell(boot_active) |-> boot_cnt <= BW'(1);
	endproperty
	a_boot_len: assert property (p_boot_len) else $error("boot period ended early"); // RULE17

endmodule

`default_nettype wire

// ===== sim/ext_mem_model.sv
// Behavioural external SRAM on the paged memory bus
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
	// Clock and pins
	input  wire logic                  pclk,
	input  wire ext_mem_pkg::ext_bus_s bus,
	input  wire logic [15:0]           d_out,
	output logic      [15:0]           d_in
);
	logic [15:0] mem [256];
	logic [15:0] last;
	logic        cs;
	// ========
	// Strobes count only while a select is low
	assign cs = !(bus.ram_chip_select_n && bus.rom_chip_select_n
		&& bus.paged_window_select_n);
	// Answers at once, so any access time is met; idle pins flip to expose stale sampling
	assign d_in = (cs && !bus.rd_n) ? mem[bus.addr[7:0]] : ~last;
	initial begin
		last = 16'h0000;
		mem[0] = ext_mem_pkg::BOOT_SIG;
	end
	always @(posedge pclk) begin
		last <= d_in;
		if (cs && !bus.wr_n) begin
			mem[bus.addr[7:0]] <= d_out;
		end
	end
endmodule
`default_nettype wire

// ===== sim/test_external_memory_paging_interface.sv
// Self-checking bench for the external memory paging interface
`timescale 1ns/100ps
`default_nettype none
module test_external_memory_paging_interface;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, flt;
	logic        cpu_req, cpu_fetch, cpu_write, cpu_exec_internal, cpu_ack, cpu_fault;
	logic        mem_d_oe, boot_active;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, r32;
	logic [1:0]  cpu_be, be_seen;
	logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, rd16, dma_addr, dma_ram_addr;
	logic [15:0] mem_d_in, mem_d_out;
	logic [2:0]  sel, sel_seen;
	logic [18:0] addr_seen;
	int          n_fail, n_checks, cyc;
	ext_mem_pkg::ext_bus_s ext_bus;
	// Decode table: join bits, address, expected {ram, rom, window} selects
	logic [15:0] dec_a [11] = '{16'h4000, 16'h7FFF, 16'h8000, 16'hBFFF, 16'hC100,
		16'hDFFF, 16'hBFFF, 16'h8000, 16'hC0FF, 16'hE000, 16'h3FFF};
	logic [1:0]  dec_m [11] = '{0, 0, 0, 0, 0, 0, 1, 2, 2, 0, 0};
	logic [2:0]  dec_s [11] = '{3, 3, 6, 6, 5, 5, 3, 5, 7, 7, 7};

	ext_mem_paging #(.BOOT_CYCLES(20)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cpu_req, .cpu_fetch, .cpu_write, .cpu_be, .cpu_addr, .cpu_wdata,
		.cpu_exec_internal, .cpu_ack, .cpu_rdata, .cpu_fault, .dma_addr,
		.dma_ram_addr, .ext_bus, .mem_d_in, .mem_d_out, .mem_d_oe, .boot_active
	);
	ext_mem_model mem (.pclk, .bus(ext_bus), .d_out(mem_d_out), .d_in(mem_d_in));
	assign sel = {ext_bus.ram_chip_select_n, ext_bus.rom_chip_select_n,
		ext_bus.paged_window_select_n};

	// ========
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r32 = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cpu(input logic w, f, input logic [15:0] a, d);
		cyc = 0;
		cpu_write <= w;
		cpu_fetch <= f;
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_req <= 1'b1;
		sel_seen <= 3'b111;
		do begin
			@(posedge pclk);
			cyc++;
		end while (cpu_ack !== 1'b1);
		flt = cpu_fault;
		rd16 = cpu_rdata;
		cpu_req <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	// ========
	// Strobe monitor: what the pins carry while a strobe is low
	always @(posedge pclk) begin
		if (presetn && !(ext_bus.rd_n && ext_bus.wr_n)) begin
			sel_seen <= sel;
			addr_seen <= ext_bus.addr;
			be_seen <= ext_bus.be_n;
			check("one_sel", 32'($countones(~sel) <= 1), 1);
			check("oe", mem_d_oe, !ext_bus.wr_n);
		end
	end
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		final_report;
	end

	// ========
	initial begin
		{presetn, psel, penable, pwrite, cpu_req, cpu_fetch, cpu_write} = '0;
		{paddr, pwdata, cpu_addr, cpu_wdata, dma_addr} = '0;
		cpu_be = 2'b01;
		cpu_exec_internal = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("boot", boot_active, 1);
		check("upper", ext_bus.addr[18:15], 4'hF);
		apb(0, ext_mem_pkg::ADDR_CTRL, 0);
		check("ctrl", r32, 16'h0070);
		apb(0, 18'h0_0000, 0);
		check("slverr", err, 1);
		apb(1, ext_mem_pkg::ADDR_PAGE1, 16'h0005);
		apb(1, ext_mem_pkg::ADDR_PAGE2, 16'h003F);
		apb(0, ext_mem_pkg::ADDR_PAGE1, 0);
		check("page1", r32, 16'h0005);
		apb(1, ext_mem_pkg::ADDR_CTRL, 16'h0010);
		cpu(0, 0, 16'h8000, 0);
		check("upper_off", addr_seen[18:15], 4'hF);
		apb(1, ext_mem_pkg::ADDR_UAE, 16'h0001);
		cpu(0, 0, 16'h8000, 0);
		check("win1", addr_seen, 19'h0_A000);
		cpu(0, 0, 16'hA004, 0);
		check("win2", addr_seen, 19'h7_E004);
		cpu(1, 0, 16'h4002, 16'h005A);
		cpu(0, 0, 16'h4002, 0);
		check("rdback", rd16[7:0], 8'h5A);
		apb(1, ext_mem_pkg::ADDR_CTRL, 16'h0014);
		cpu(0, 0, 16'h8006, 0);
		check("addr16", addr_seen[17:0], 18'h0_5003);
		check("be16", be_seen, 2'b10);
		for (int i = 0; i < 11; i++) begin
			apb(1, ext_mem_pkg::ADDR_CTRL, 16'h0010 | dec_m[i]);
			cpu(0, 0, dec_a[i], 0);
			check("select", sel_seen, dec_s[i]);
			check("fault", flt, dec_s[i] == 7);
		end
		cpu(0, 1, 16'hC010, 0);
		check("hole", {flt, sel_seen}, 4'hF);
		apb(0, ext_mem_pkg::ADDR_STATUS, 0);
		check("status", r32[3:1], 3'b101);
		for (int ws = 0; ws < 8; ws++) begin
			apb(1, ext_mem_pkg::ADDR_CTRL, 16'(ws << 4));
			cpu(0, 0, 16'h4000, 0);
			check("waits", cyc, (ws == 0 ? 1 : ws) + 4);
		end
		cpu_exec_internal <= 1'b0;
		apb(1, ext_mem_pkg::ADDR_CTRL, 16'h0030);
		apb(0, ext_mem_pkg::ADDR_CTRL, 0);
		check("ws_hold", r32, 16'h0070);
		apb(0, ext_mem_pkg::ADDR_STATUS, 0);
		check("ws_flag", r32[2], 1);
		dma_addr <= 16'h9234;
		repeat (2) @(posedge pclk);
		check("dma", dma_ram_addr, 16'h1234);
		check("boot_end", boot_active, 0);
		final_report;
	end
endmodule
`default_nettype wire
